// *** core/psr_params.svh ***
// Constants for the program suspend and resume controller.
// Assumes a 100 MHz core clock and a 32-bit Wishbone register port.
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

`define PSR_CLK_MHZ 100
`define PSR_SUSP_LAT_NS 50
`define PSR_SUSP_LAT_CYC ((`PSR_SUSP_LAT_NS * `PSR_CLK_MHZ) / 1000)
`define PSR_PROG_TIME_NS 2000
`define PSR_PROG_CYC ((`PSR_PROG_TIME_NS * `PSR_CLK_MHZ + 999) / 1000)

`define PSR_CMD_OFS 8'h00
`define PSR_ADDR_OFS 8'h04
`define PSR_DATA_OFS 8'h08
`define PSR_IRQ_STAT_OFS 8'h0C
`define PSR_IRQ_CLR_OFS 8'h10
`define PSR_IRQ_EN_OFS 8'h14

`define PSR_CMD_SETUP 8'h40
`define PSR_CMD_SETUP_ALT 8'h10
`define PSR_CMD_SUSPEND 8'hB0
`define PSR_CMD_RESUME 8'hD0
`define PSR_CMD_READ_ARRAY 8'hFF
`define PSR_CMD_READ_STATUS 8'h70

`define PSR_READY_POS 7
`define PSR_SUSP_POS 2
`define PSR_IRQ_SUSP_POS 0
`define PSR_IRQ_DONE_POS 1
`define PSR_IRQ_REJ_POS 2
`define PSR_ARRAY_RESET 16'hFFFF

`endif

// *** core/psr_pkg.sv ***
// Types for the program suspend and resume controller.
// Assumes psr_params.svh is on the include path.
package psr_pkg;
    typedef enum logic [4:0] {
        PSR_IDLE = 5'h01,
        PSR_SETUP = 5'h02,
        PSR_PROG = 5'h04,
        PSR_SUSP_PEND = 5'h08,
        PSR_SUSPENDED = 5'h10
    } psr_state_t;
    typedef logic [15:0] psr_word_t;
    typedef logic [3:0] psr_addr_t;
endpackage

// *** core/psr_timer.sv ***
// Pausable down counter used for program time and suspend latency.
// Assumes load and run come from the same clock domain.
`timescale 1ns/1ps
module psr_timer (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic load_in,
    input wire logic [7:0] load_val_in,
    input wire logic run_in,
    output logic done_out
);
    logic [7:0] count_reg;

    // Count holds while run is low, so a paused program keeps its progress
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            count_reg <= 8'h00;
        end else if (load_in) begin
            count_reg <= load_val_in;
        end else if (run_in && count_reg != 8'h00) begin
            count_reg <= count_reg - 8'h01;
        end
    end

    assign done_out = run_in && !load_in && count_reg == 8'h01;
endmodule // psr_timer

// *** core/psr_ctrl.sv ***
// Program suspend and resume controller with a small word array.
// Assumes a classic Wishbone master on the same clock, synchronous pins.
//
// How it works
// RULE1 - Suspend during programming halts it after a bounded latency.
// RULE2 - Accepted suspend switches reads to status until another read mode.
// RULE3 - Once halted, ready and suspended status bits both read one.
// RULE4 - While suspended, read array returns data outside the suspended block.
// RULE5 - While suspended only read array, read status and resume are valid.
// RULE6 - Chip select high while suspended enters pseudo-standby, suspension kept.
// RULE7 - Host holds write protect steady while suspended.
// RULE8 - Resume restarts programming and clears ready and suspended bits.
// RULE9 - After resume, reads return status until another read mode.
// RULE10 - Suspended bit stays set from suspension until resume.
// RULE11 - Host starts programming with setup 40H or 10H then address and data.
// RULE12 - Invalid commands while suspended are rejected; stray resume in idle does nothing.
`timescale 1ns/1ps
`include "psr_params.svh"
module psr_ctrl (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic chip_sel_b_in,
    input wire logic write_protect_b_in,
    output logic ready_out,
    output logic suspended_out,
    output logic standby_out,
    output logic irq_out
);
    import psr_pkg::*;

    psr_state_t state_reg;
    psr_state_t state_next;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic mode_status_reg;
    logic ready_reg;
    logic susp_reg;
    logic standby_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_en_reg;
    logic irq_reg;
    psr_addr_t addr_reg;
    psr_addr_t prog_addr_reg;
    psr_word_t prog_data_reg;
    psr_word_t array_mem [0:15];
    logic acc;
    logic wr;
    logic rd;
    logic cmd_wr;
    logic data_wr;
    logic [7:0] cmd;
    logic is_setup;
    logic prog_start;
    logic susp_accept;
    logic resume_accept;
    logic cmd_reject;
    logic prog_done;
    logic lat_done;
    logic [7:0] status_byte;
    logic [2:0] irq_event;

    assign acc = wb_cyc_in && wb_stb_in && !ack_reg;
    assign wr = acc && wb_we_in && wb_sel_in[0];
    assign rd = acc && !wb_we_in;
    assign cmd_wr = wr && wb_adr_in == `PSR_CMD_OFS;
    assign data_wr = wr && wb_adr_in == `PSR_DATA_OFS;
    assign cmd = wb_dat_in[7:0];
    assign is_setup = cmd == `PSR_CMD_SETUP || cmd == `PSR_CMD_SETUP_ALT;

    always_comb begin
        status_byte = 8'h00;
        status_byte[`PSR_READY_POS] = ready_reg;
        status_byte[`PSR_SUSP_POS] = susp_reg;
    end

    psr_timer u_prog_timer (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .load_in(prog_start),
        .load_val_in(8'(`PSR_PROG_CYC)),
        .run_in(state_reg == PSR_PROG || state_reg == PSR_SUSP_PEND),
        .done_out(prog_done)
    );

    psr_timer u_lat_timer (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .load_in(susp_accept),
        .load_val_in(8'(`PSR_SUSP_LAT_CYC)),
        .run_in(state_reg == PSR_SUSP_PEND),
        .done_out(lat_done)
    );

    always_comb begin
        state_next = state_reg;
        prog_start = 1'b0;
        susp_accept = 1'b0;
        resume_accept = 1'b0;
        cmd_reject = 1'b0;
        case (state_reg)
            PSR_IDLE: begin
                if (cmd_wr && is_setup) begin
                    state_next = PSR_SETUP; // [RULE11]
                end
            end
            PSR_SETUP: begin
                if (data_wr) begin
                    state_next = PSR_PROG;
                    prog_start = 1'b1;
                end else if (cmd_wr) begin
                    cmd_reject = 1'b1;
                end
            end
            PSR_PROG: begin
                if (prog_done) begin
                    state_next = PSR_IDLE;
                end else if (cmd_wr && cmd == `PSR_CMD_SUSPEND) begin
                    state_next = PSR_SUSP_PEND; // [RULE1]
                    susp_accept = 1'b1;
                end else if (cmd_wr && cmd != `PSR_CMD_READ_STATUS) begin
                    cmd_reject = 1'b1;
                end
            end
            PSR_SUSP_PEND: begin
                // A program that ends inside the latency simply completes
                if (prog_done) begin
                    state_next = PSR_IDLE;
                end else if (lat_done) begin
                    state_next = PSR_SUSPENDED; // [RULE1]
                end else if (cmd_wr && cmd != `PSR_CMD_READ_STATUS) begin
                    cmd_reject = 1'b1;
                end
            end
            PSR_SUSPENDED: begin
                if (cmd_wr && cmd == `PSR_CMD_RESUME) begin
                    state_next = PSR_PROG; // [RULE8]
                    resume_accept = 1'b1;
                end else if (cmd_wr && cmd != `PSR_CMD_READ_ARRAY &&
                        cmd != `PSR_CMD_READ_STATUS) begin
                    cmd_reject = 1'b1; // [RULE5] [RULE12]
                end
            end
            default: begin
                state_next = PSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            state_reg <= PSR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Status bits follow the state; leaving suspension needs a resume
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            ready_reg <= 1'b1;
            susp_reg <= 1'b0;
        end else begin
            ready_reg <= state_next == PSR_IDLE || state_next == PSR_SETUP ||
                state_next == PSR_SUSPENDED; // [RULE3] [RULE8]
            susp_reg <= state_next == PSR_SUSPENDED; // [RULE3] [RULE10]
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            mode_status_reg <= 1'b0;
        end else if (susp_accept || resume_accept || prog_start) begin
            mode_status_reg <= 1'b1; // [RULE2] [RULE9]
        end else if (cmd_wr && state_reg == PSR_IDLE && is_setup) begin
            mode_status_reg <= 1'b1;
        end else if (cmd_wr && cmd == `PSR_CMD_READ_STATUS) begin
            mode_status_reg <= 1'b1;
        end else if (cmd_wr && cmd == `PSR_CMD_READ_ARRAY &&
                (state_reg == PSR_IDLE || state_reg == PSR_SUSPENDED)) begin
            mode_status_reg <= 1'b0; // [RULE4]
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            addr_reg <= 4'h0;
        end else if (wr && wb_adr_in == `PSR_ADDR_OFS) begin
            addr_reg <= wb_dat_in[3:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            prog_addr_reg <= 4'h0;
            prog_data_reg <= 16'h0000;
        end else if (prog_start) begin
            prog_addr_reg <= addr_reg;
            prog_data_reg <= wb_dat_in[15:0];
        end
    end

    // Programming can only clear bits, as a real cell would
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < 16; i++) begin
                array_mem[i] <= `PSR_ARRAY_RESET;
            end
        end else if (prog_done) begin
            array_mem[prog_addr_reg] <= array_mem[prog_addr_reg] & prog_data_reg;
        end
    end

    // Pseudo-standby only flags low activity; the suspended state is untouched
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            standby_reg <= 1'b0;
        end else begin
            standby_reg <= state_next == PSR_SUSPENDED && chip_sel_b_in; // [RULE6]
        end
    end

    always_comb begin
        irq_event = 3'h0;
        irq_event[`PSR_IRQ_SUSP_POS] = state_reg == PSR_SUSP_PEND &&
            state_next == PSR_SUSPENDED;
        irq_event[`PSR_IRQ_DONE_POS] = prog_done;
        irq_event[`PSR_IRQ_REJ_POS] = cmd_reject;
    end

    // A new event wins over a clear in the same cycle
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            irq_stat_reg <= 3'h0;
        end else if (wr && wb_adr_in == `PSR_IRQ_CLR_OFS) begin
            irq_stat_reg <= (irq_stat_reg & ~wb_dat_in[2:0]) | irq_event;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_event;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            irq_en_reg <= 3'h0;
        end else if (wr && wb_adr_in == `PSR_IRQ_EN_OFS) begin
            irq_en_reg <= wb_dat_in[2:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // One wait state: ack and read data are both registered
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= acc;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd) begin
            if (wb_adr_in == `PSR_CMD_OFS) begin
                rdata_reg <= {27'h0, state_reg};
            end else if (wb_adr_in == `PSR_ADDR_OFS) begin
                rdata_reg <= {28'h0, addr_reg};
            end else if (wb_adr_in == `PSR_DATA_OFS) begin
                if (mode_status_reg) begin
                    rdata_reg <= {24'h0, status_byte}; // [RULE2] [RULE9]
                end else if (state_reg == PSR_SUSPENDED &&
                        addr_reg[3:2] == prog_addr_reg[3:2]) begin
                    rdata_reg <= {24'h0, status_byte};
                end else begin
                    rdata_reg <= {16'h0, array_mem[addr_reg]}; // [RULE4]
                end
            end else if (wb_adr_in == `PSR_IRQ_STAT_OFS) begin
                rdata_reg <= {29'h0, irq_stat_reg};
            end else if (wb_adr_in == `PSR_IRQ_EN_OFS) begin
                rdata_reg <= {29'h0, irq_en_reg};
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end

    assign wb_ack_out = ack_reg;
    assign wb_dat_out = rdata_reg;
    assign ready_out = ready_reg;
    assign suspended_out = susp_reg;
    assign standby_out = standby_reg;
    assign irq_out = irq_reg;

    property p_susp_bounded; // [RULE1]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        susp_accept |-> ##[1:8] state_reg != PSR_SUSP_PEND;
    endproperty
    a_susp_bounded: assert property (p_susp_bounded) // [RULE1]
        else $error("suspend latency exceeded");

    property p_susp_status; // [RULE2]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        susp_accept |=> mode_status_reg;
    endproperty
    a_susp_status: assert property (p_susp_status) // [RULE2]
        else $error("no status mode after suspend");

    property p_halted_bits; // [RULE3]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        state_reg == PSR_SUSP_PEND && state_next == PSR_SUSPENDED |=>
            ready_out && suspended_out;
    endproperty
    a_halted_bits: assert property (p_halted_bits) // [RULE3]
        else $error("halt bits not set");

    property p_array_read; // [RULE4]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        rd && wb_adr_in == `PSR_DATA_OFS && state_reg == PSR_SUSPENDED && !mode_status_reg
            && addr_reg[3:2] != prog_addr_reg[3:2]
            |=> wb_dat_out[15:0] == array_mem[$past(addr_reg)];
    endproperty
    a_array_read: assert property (p_array_read) // [RULE4]
        else $error("wrong array data");

    property p_reject_keeps; // [RULE12]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        state_reg == PSR_SUSPENDED && cmd_reject |=> state_reg == PSR_SUSPENDED && susp_reg;
    endproperty
    a_reject_keeps: assert property (p_reject_keeps) // [RULE12]
        else $error("reject left suspend");

    property p_standby; // [RULE6]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        state_reg == PSR_SUSPENDED && chip_sel_b_in && !cmd_wr |=> standby_out;
    endproperty
    a_standby: assert property (p_standby) // [RULE6]
        else $error("no pseudo-standby");

    property p_resume; // [RULE8]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        resume_accept |=> state_reg == PSR_PROG && !ready_out && !suspended_out
            && mode_status_reg;
    endproperty
    a_resume: assert property (p_resume) // [RULE8]
        else $error("resume did not restart");

    property p_susp_held; // [RULE10]
        @(posedge core_clk_in) disable iff (!rst_b_in)
        $fell(suspended_out) |-> $past(resume_accept);
    endproperty
    a_susp_held: assert property (p_susp_held) // [RULE10]
        else $error("suspend bit dropped early");
endmodule // psr_ctrl

// *** testbench/psr_host_model.sv ***
// Host model: a classic Wishbone master that issues flash commands.
// Assumes one clock shared with the controller and one request at a time.
`timescale 1ns/1ps
`include "psr_params.svh"
module psr_host_model (
    input wire logic core_clk_in,
    input wire logic wb_ack_in,
    input wire logic [31:0] wb_dat_in,
    output logic wb_cyc_out,
    output logic wb_stb_out,
    output logic wb_we_out,
    output logic [7:0] wb_adr_out,
    output logic [3:0] wb_sel_out,
    output logic [31:0] wb_dat_out
);
    import psr_pkg::*;
    initial begin
        wb_cyc_out = 1'b0;
        wb_stb_out = 1'b0;
        wb_we_out = 1'b0;
        wb_adr_out = 8'h00;
        wb_sel_out = 4'h0;
        wb_dat_out = 32'h0;
    end
    // Request held until ack is sampled high; no cycle count is assumed
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        output logic [31:0] rdat);
        @(posedge core_clk_in);
        wb_cyc_out <= 1'b1;
        wb_stb_out <= 1'b1;
        wb_we_out <= we;
        wb_adr_out <= adr;
        wb_sel_out <= 4'hF;
        wb_dat_out <= dat;
        do @(posedge core_clk_in); while (wb_ack_in !== 1'b1);
        rdat = wb_dat_in;
        wb_cyc_out <= 1'b0;
        wb_stb_out <= 1'b0;
        wb_we_out <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] tmp;
        xfer(1'b1, adr, dat, tmp);
    endtask
    task automatic rd(input logic [7:0] adr, output logic [31:0] d);
        xfer(1'b0, adr, 32'h0, d);
    endtask
    // Setup code then the data word, at the address set beforehand
    task automatic prog(input logic [7:0] setup, input logic [15:0] d);
        wr(`PSR_CMD_OFS, {24'h0, setup});
        wr(`PSR_DATA_OFS, {16'h0, d});
    endtask
endmodule // psr_host_model

// *** testbench/tb.sv ***
// Self-checking bench for the program suspend and resume controller.
// Assumes the host model drives the bus; pins are driven here.
`timescale 1ns/1ps
`include "psr_params.svh"
module tb;
    import psr_pkg::*;
    logic core_clk_in, rst_b_in, chip_sel_b_in, write_protect_b_in;
    logic wb_cyc, wb_stb, wb_we, wb_ack, ready, susp, stby, irq;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat, rd;
    int n_fail, cmp_count;
    psr_ctrl psr_ctrl_inst (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
        .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
        .chip_sel_b_in(chip_sel_b_in), .write_protect_b_in(write_protect_b_in),
        .ready_out(ready), .suspended_out(susp), .standby_out(stby), .irq_out(irq));
    psr_host_model psr_host_model_inst (.core_clk_in(core_clk_in), .wb_ack_in(wb_ack),
        .wb_dat_in(wb_rdat), .wb_cyc_out(wb_cyc), .wb_stb_out(wb_stb), .wb_we_out(wb_we),
        .wb_adr_out(wb_adr), .wb_sel_out(wb_sel), .wb_dat_out(wb_wdat));
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        psr_host_model_inst.wr(a, d);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        psr_host_model_inst.rd(a, rd);
        chk(nm, e, rd & m);
    endtask
    // Pins as {ready, suspended, standby, irq}, looked at after the next edge settles
    task automatic pins(input string nm, input logic [3:0] e);
        @(posedge core_clk_in);
        #1;
        chk(nm, {28'h0, e}, {28'h0, ready, susp, stby, irq});
    endtask
    // Bounded wait: the 200-cycle program time is below this 300-cycle limit
    task automatic wait_ready;
        for (int i = 0; i < 300 && ready !== 1'b1; i++) begin
            @(posedge core_clk_in);
        end
        // A wait that runs out is a failure in its own right
        if (ready !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED ready wait expected 1 seen %b", ready);
        end
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    initial begin
        repeat (5000) @(posedge core_clk_in);
        n_fail++;
        end_of_test();
    end
    initial begin
        rst_b_in = 1'b0;
        chip_sel_b_in = 1'b0;
        write_protect_b_in = 1'b1;
        repeat (5) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        pins("reset pins", 4'b1000);
        rdchk("reset array", `PSR_DATA_OFS, 32'hFFFF, 32'hFFFF);
        wr(8'h20, 32'h55);
        rdchk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
        $display("test reset done");
        wr(`PSR_IRQ_EN_OFS, 32'h1);
        wr(`PSR_ADDR_OFS, 32'h1);
        psr_host_model_inst.prog(`PSR_CMD_SETUP, 16'h00F0);
        pins("programming", 4'b0000);
        wr(`PSR_CMD_OFS, 32'hB0);
        rdchk("status early", `PSR_DATA_OFS, 32'h84, 32'h0);
        repeat (3) @(posedge core_clk_in);
        pins("halted", 4'b1101);
        rdchk("status halted", `PSR_DATA_OFS, 32'h84, 32'h84);
        rdchk("state", `PSR_CMD_OFS, 32'h1F, 32'h10);
        wr(`PSR_IRQ_CLR_OFS, 32'h1);
        pins("irq cleared", 4'b1100);
        $display("test suspend done");
        wr(`PSR_CMD_OFS, 32'h40);
        wr(`PSR_CMD_OFS, 32'h10);
        wr(`PSR_CMD_OFS, 32'hB0);
        rdchk("still suspended", `PSR_CMD_OFS, 32'h1F, 32'h10);
        rdchk("reject flag", `PSR_IRQ_STAT_OFS, 32'h7, 32'h4);
        pins("reject masked", 4'b1100);
        wr(`PSR_IRQ_EN_OFS, 32'h7);
        pins("reject irq", 4'b1101);
        wr(`PSR_IRQ_CLR_OFS, 32'h7);
        pins("reject clr", 4'b1100);
        @(posedge core_clk_in);
        chip_sel_b_in <= 1'b1;
        pins("standby", 4'b1110);
        rdchk("standby state", `PSR_CMD_OFS, 32'h1F, 32'h10);
        chip_sel_b_in <= 1'b0;
        pins("awake", 4'b1100);
        $display("test reject done");
        wr(`PSR_CMD_OFS, 32'hFF);
        wr(`PSR_ADDR_OFS, 32'h5);
        rdchk("other block", `PSR_DATA_OFS, 32'hFFFF, 32'hFFFF);
        wr(`PSR_ADDR_OFS, 32'h1);
        rdchk("own block", `PSR_DATA_OFS, 32'h84, 32'h84);
        wr(`PSR_CMD_OFS, 32'h70);
        wr(`PSR_ADDR_OFS, 32'h5);
        rdchk("status mode", `PSR_DATA_OFS, 32'h84, 32'h84);
        $display("test read done");
        wr(`PSR_CMD_OFS, 32'hD0);
        pins("resumed", 4'b0000);
        rdchk("resume status", `PSR_DATA_OFS, 32'h84, 32'h0);
        rdchk("resume state", `PSR_CMD_OFS, 32'h1F, 32'h04);
        wait_ready();
        pins("done", 4'b1001);
        wr(`PSR_IRQ_CLR_OFS, 32'h7);
        wr(`PSR_CMD_OFS, 32'hFF);
        wr(`PSR_ADDR_OFS, 32'h1);
        rdchk("programmed", `PSR_DATA_OFS, 32'hFFFF, 32'h00F0);
        wr(`PSR_CMD_OFS, 32'hD0);
        pins("stray resume", 4'b1000);
        rdchk("stray flag", `PSR_IRQ_STAT_OFS, 32'h7, 32'h0);
        rdchk("stray state", `PSR_CMD_OFS, 32'h1F, 32'h01);
        $display("test resume done");
        wr(`PSR_ADDR_OFS, 32'h8);
        psr_host_model_inst.prog(`PSR_CMD_SETUP_ALT, 16'h1234);
        rdchk("alt prog", `PSR_CMD_OFS, 32'h1F, 32'h04);
        wait_ready();
        wr(`PSR_CMD_OFS, 32'hFF);
        rdchk("alt data", `PSR_DATA_OFS, 32'hFFFF, 32'h1234);
        $display("test alt setup done");
        end_of_test();
    end
endmodule // tb
